// ---- hw/dcff_defines.svh ----
// constants for the dual clock fifo flag logic and its controller
// assumes one clock domain shared by both ends
// Notes on behaviour
// R01 - mode select latched during reset, held stable
// R02 - standard mode: every word needs read enable
// R03 - fall-through: first word shows after three edges
// R04 - fall-through: later words need read enable
// R05 - output-ready low with data, input-ready low with space
// R06 - write enable low stores word unless full
// R07 - standard: empty flag rises after first write
// R08 - almost-empty rises at count n plus one
// R09 - half-full falls at half depth plus one
// R10 - almost-full falls at depth minus m
// R11 - full flag falls at depth, writes ignored
// R12 - first read releases full flag
// R13 - draining raises almost-full and half-full again
// R14 - almost-empty falls at count n
// R15 - empty flag falls after last word read
// R16 - read enable ignored while empty
// R17 - empty and full flags double registered
// R18 - output-ready triple, input-ready double registered
// R19 - fall-through holds one extra word
// R20 - reset clears pointers, count, loads default offsets
`ifndef DCFF_DEFINES_SVH
`define DCFF_DEFINES_SVH
`define DCFF_WIDTH         36
`define DCFF_DEPTH         1024
`define DCFF_AW            10
`define DCFF_CW            11
`define DCFF_DEPTH_CNT     11'h400
`define DCFF_HALF_CNT      11'h200
`define DCFF_DEF_EMPTY_OFS 11'h07f
`define DCFF_DEF_FULL_OFS  11'h07f
`define DCFF_STAGE_DEPTH   32
`endif

// ---- hw/dcff_pkg.sv ----
// types shared by both ends of the fifo link
// assumes dcff_defines.svh on the include path
`include "dcff_defines.svh"
package dcff_pkg;
  typedef logic [`DCFF_WIDTH-1:0] dcff_word_t;
  typedef logic [`DCFF_CW-1:0]    dcff_cnt_t;
  typedef enum logic [2:0] {
    DCFF_RD_IDLE = 3'b001,
    DCFF_RD_WAIT = 3'b010,
    DCFF_RD_CAPT = 3'b100
  } dcff_rd_state_t;
endpackage : dcff_pkg

// ---- hw/dcff_if.sv ----
// pin level link between the fifo and its controller
// assumes both ends run on the same clock
`timescale 1ns/1ns
`include "dcff_defines.svh"
interface dcff_if;
  logic                   wr_en_n;
  logic [`DCFF_WIDTH-1:0] data_in;
  logic                   rd_en_n;
  logic [`DCFF_WIDTH-1:0] data_out_bus;
  logic                   timing_mode_select_in;
  logic                   empty_flag_n;
  logic                   full_flag_n;
  logic                   output_ready_n;
  logic                   input_ready_n;
  logic                   almost_empty_flag_n;
  logic                   almost_full_flag_n;
  logic                   half_full_flag_n;
  modport device (
    input  wr_en_n, data_in, rd_en_n, timing_mode_select_in,
    output data_out_bus, empty_flag_n, full_flag_n, output_ready_n, input_ready_n,
    output almost_empty_flag_n, almost_full_flag_n, half_full_flag_n
  );
  modport host (
    output wr_en_n, data_in, rd_en_n, timing_mode_select_in,
    input  data_out_bus, empty_flag_n, full_flag_n, output_ready_n, input_ready_n,
    input  almost_empty_flag_n, almost_full_flag_n, half_full_flag_n
  );
endinterface : dcff_if

// ---- hw/dcff_stage_fifo.sv ----
// small staging fifo with valid and ready on both sides
// assumes a single clock and synchronous active high reset
`timescale 1ns/1ns
module dcff_stage_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  logic             in_ready_ff;
  logic             out_valid_ff;
  logic             push;
  logic             pop;

  assign push      = in_valid & in_ready_ff;
  assign pop       = out_valid_ff & out_ready;
  assign nxt_cnt   = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready  = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data  = mem[rd_ptr_ff];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_ff    <= '0;
      rd_ptr_ff    <= '0;
      cnt_ff       <= '0;
      in_ready_ff  <= 1'b0;
      out_valid_ff <= 1'b0;
    end else begin
      wr_ptr_ff    <= wr_ptr_ff + AW'(push);
      rd_ptr_ff    <= rd_ptr_ff + AW'(pop);
      cnt_ff       <= nxt_cnt;
      in_ready_ff  <= nxt_cnt != (AW+1)'(DEPTH);
      out_valid_ff <= nxt_cnt != '0;
    end
  end
endmodule : dcff_stage_fifo

// ---- hw/dcff_device.sv ----
// fifo core with standard and fall-through timing and its status flags
// assumes writer and reader share clk; link signals need no synchroniser
`timescale 1ns/1ns
`include "dcff_defines.svh"
module dcff_device
  import dcff_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // link to the controller
  dcff_if.device    link,
  // status
  output logic      first_word_fallthrough_mode_active,
  output dcff_cnt_t word_count
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  dcff_word_t            mem [`DCFF_DEPTH];
  logic                  first_word_fallthrough_mode_ff;
  dcff_cnt_t             empty_ofs_ff;
  dcff_cnt_t             full_ofs_ff;
  logic [`DCFF_AW-1:0]   wr_ptr_ff;
  logic [`DCFF_AW-1:0]   rd_ptr_ff;
  dcff_cnt_t             cnt_ff;
  dcff_cnt_t             level_ff;
  logic                  ovalid_ff;
  dcff_word_t            data_out_ff;
  logic [1:0]            ne_ff;
  logic                  space_ff;
  logic                  empty_flag_n_ff;
  logic                  full_flag_n_ff;
  logic                  output_ready_n_ff;
  logic                  input_ready_n_ff;
  logic                  almost_empty_n_ff;
  logic                  almost_full_n_ff;
  logic                  half_full_n_ff;

  // ----------------------------------------
  // next values
  // ----------------------------------------
  logic                  do_wr;
  logic                  mem_ok;
  logic                  do_take;
  logic                  do_pop;
  logic                  nxt_ovalid;
  dcff_cnt_t             nxt_cnt;
  dcff_cnt_t             nxt_level;
  dcff_cnt_t             adj;

  // write when enabled and the array has room
  assign do_wr = !link.wr_en_n && (cnt_ff != `DCFF_DEPTH_CNT); // R06 R11

  // array counts as holding data once the count has passed two stages
  assign mem_ok = (cnt_ff != '0) && ne_ff[1]; // R16

  // fall-through: reader takes the word standing on the outputs
  assign do_take = first_word_fallthrough_mode_ff && !link.rd_en_n && ovalid_ff; // R04

  always_comb begin
    if (first_word_fallthrough_mode_ff) begin
      do_pop = mem_ok && (!ovalid_ff || do_take); // R03 R04
    end else begin
      do_pop = !link.rd_en_n && mem_ok; // R02 R16
    end
  end

  always_comb begin
    if (first_word_fallthrough_mode_ff) begin
      nxt_ovalid = do_pop | (ovalid_ff & ~do_take);
    end else begin
      nxt_ovalid = 1'b0;
    end
  end

  assign nxt_cnt = cnt_ff + dcff_cnt_t'(do_wr) - dcff_cnt_t'(do_pop);

  // output register adds one word to capacity in fall-through
  assign nxt_level = nxt_cnt + dcff_cnt_t'(nxt_ovalid); // R19

  // fall-through thresholds sit one word higher
  assign adj = dcff_cnt_t'(first_word_fallthrough_mode_ff);

  // ----------------------------------------
  // timing mode
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      first_word_fallthrough_mode_ff <= link.timing_mode_select_in; // R01
    end
  end

  // ----------------------------------------
  // flag offsets
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      empty_ofs_ff <= `DCFF_DEF_EMPTY_OFS; // R20
      full_ofs_ff  <= `DCFF_DEF_FULL_OFS; // R20
    end
  end

  // ----------------------------------------
  // storage array
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_ff] <= link.data_in; // R06
    end
  end

  // ----------------------------------------
  // pointers and count
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_ff <= '0; // R20
      rd_ptr_ff <= '0; // R20
      cnt_ff    <= '0; // R20
      level_ff  <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + `DCFF_AW'(do_wr);
      rd_ptr_ff <= rd_ptr_ff + `DCFF_AW'(do_pop);
      cnt_ff    <= nxt_cnt;
      level_ff  <= nxt_level;
    end
  end

  // ----------------------------------------
  // output register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      data_out_ff <= '0;
      ovalid_ff   <= 1'b0;
    end else begin
      ovalid_ff <= nxt_ovalid;
      if (do_pop) begin
        data_out_ff <= mem[rd_ptr_ff]; // R02 R03
      end
    end
  end

  // ----------------------------------------
  // empty side stages
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ne_ff <= 2'h0;
    end else begin
      ne_ff <= {ne_ff[0], cnt_ff != '0}; // R17 R18
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      empty_flag_n_ff <= 1'b0; // R20
    end else if (first_word_fallthrough_mode_ff) begin
      empty_flag_n_ff <= 1'b1;
    end else begin
      empty_flag_n_ff <= ne_ff[0] && (cnt_ff != '0); // R07 R15 R17
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      output_ready_n_ff <= 1'b1;
    end else if (first_word_fallthrough_mode_ff) begin
      output_ready_n_ff <= !nxt_ovalid; // R05 R18
    end else begin
      output_ready_n_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // full side stages
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      space_ff <= 1'b1;
    end else if (first_word_fallthrough_mode_ff) begin
      space_ff <= nxt_level != (`DCFF_DEPTH_CNT + 11'h001); // R19
    end else begin
      space_ff <= nxt_cnt != `DCFF_DEPTH_CNT; // R11 R12
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      full_flag_n_ff   <= 1'b1; // R20
      input_ready_n_ff <= 1'b1;
    end else if (first_word_fallthrough_mode_ff) begin
      full_flag_n_ff   <= 1'b1;
      input_ready_n_ff <= !space_ff; // R05 R18
    end else begin
      full_flag_n_ff   <= space_ff; // R11 R12 R17
      input_ready_n_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // programmable and half flags
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      almost_empty_n_ff <= 1'b0;
      half_full_n_ff    <= 1'b1;
      almost_full_n_ff  <= 1'b1;
    end else begin
      almost_empty_n_ff <= nxt_level >= (empty_ofs_ff + 11'h001 + adj); // R08 R14
      half_full_n_ff    <= !(nxt_level >= (`DCFF_HALF_CNT + 11'h001 + adj)); // R09 R13
      almost_full_n_ff  <= !(nxt_level >= (`DCFF_DEPTH_CNT - full_ofs_ff + adj)); // R10 R13
    end
  end

  // ----------------------------------------
  // link outputs
  // ----------------------------------------
  assign link.data_out_bus        = data_out_ff;
  assign link.empty_flag_n        = empty_flag_n_ff;
  assign link.full_flag_n         = full_flag_n_ff;
  assign link.output_ready_n      = output_ready_n_ff;
  assign link.input_ready_n       = input_ready_n_ff;
  assign link.almost_empty_flag_n = almost_empty_n_ff;
  assign link.almost_full_flag_n  = almost_full_n_ff;
  assign link.half_full_flag_n    = half_full_n_ff;
  assign first_word_fallthrough_mode_active              = first_word_fallthrough_mode_ff;
  assign word_count               = level_ff;

endmodule : dcff_device

// ---- hw/dcff_host.sv ----
// controller that feeds the fifo and collects words from it
// assumes the fifo end shares clk; user side is valid and ready
`timescale 1ns/1ns
`include "dcff_defines.svh"
module dcff_host
  import dcff_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // link to the fifo
  dcff_if.host            link,
  // mode request, held through reset
  input  wire logic       mode_sel,
  // write stream
  input  wire logic       wr_valid,
  input  wire dcff_word_t wr_data,
  output logic            wr_ready,
  // read stream
  output logic            rd_valid,
  output dcff_word_t      rd_data,
  input  wire logic       rd_ready
);

  // ----------------------------------------
  // staging buffer
  // ----------------------------------------
  logic           st_valid;
  dcff_word_t     st_data;
  logic           st_pop;
  logic           mode_ff;
  logic           wr_en_n_ff;
  dcff_word_t     data_in_ff;
  logic           rd_en_n_ff;
  logic           rd_valid_ff;
  dcff_word_t     rd_data_ff;
  dcff_rd_state_t rd_state_ff;

  dcff_stage_fifo #(
    .WIDTH (`DCFF_WIDTH),
    .DEPTH (`DCFF_STAGE_DEPTH)
  ) u_stage (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (wr_valid),
    .in_data   (wr_data),
    .in_ready  (wr_ready),
    .out_valid (st_valid),
    .out_data  (st_data),
    .out_ready (st_pop)
  );

  // ----------------------------------------
  // mode select
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ff <= mode_sel; // R01
    end
  end

  // ----------------------------------------
  // write side
  // ----------------------------------------
  // almost-full margin covers the flag lag, so no write is dropped
  assign st_pop = st_valid && link.almost_full_flag_n;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_en_n_ff <= 1'b1;
      data_in_ff <= '0;
    end else begin
      wr_en_n_ff <= !st_pop; // R06
      if (st_pop) begin
        data_in_ff <= st_data;
      end
    end
  end

  // ----------------------------------------
  // read side
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_state_ff <= DCFF_RD_IDLE;
      rd_en_n_ff  <= 1'b1;
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= '0;
    end else begin
      rd_en_n_ff <= 1'b1;
      if (rd_valid_ff && rd_ready) begin
        rd_valid_ff <= 1'b0;
      end
      unique case (rd_state_ff)
        DCFF_RD_IDLE: begin
          if (!rd_valid_ff && mode_ff && !link.output_ready_n) begin
            rd_en_n_ff  <= 1'b0; // R04 R05
            rd_data_ff  <= link.data_out_bus;
            rd_valid_ff <= 1'b1;
            rd_state_ff <= DCFF_RD_WAIT;
          end else if (!rd_valid_ff && !mode_ff && link.empty_flag_n) begin
            rd_en_n_ff  <= 1'b0; // R02
            rd_state_ff <= DCFF_RD_WAIT;
          end
        end
        DCFF_RD_WAIT: begin
          rd_state_ff <= mode_ff ? DCFF_RD_IDLE : DCFF_RD_CAPT;
        end
        DCFF_RD_CAPT: begin
          rd_data_ff  <= link.data_out_bus;
          rd_valid_ff <= 1'b1;
          rd_state_ff <= DCFF_RD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign link.timing_mode_select_in = mode_ff;
  assign link.wr_en_n               = wr_en_n_ff;
  assign link.data_in               = data_in_ff;
  assign link.rd_en_n               = rd_en_n_ff;
  assign rd_valid                   = rd_valid_ff;
  assign rd_data                    = rd_data_ff;

endmodule : dcff_host

// ---- bench/dcff_link_asserts.sv ----
// checker for the link between the fifo and its controller
// assumes one clock; placed beside the interface by the bench
`timescale 1ns/1ns
module dcff_link_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  input wire logic wr_en_n,
  input wire logic rd_en_n,
  input wire logic timing_mode_select_in,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic output_ready_n,
  input wire logic input_ready_n,
  input wire logic almost_empty_flag_n,
  input wire logic almost_full_flag_n,
  input wire logic half_full_flag_n
);
  // ---------------------------------------------
  // settle time after reset
  // ---------------------------------------------
  logic [1:0] up_ff;
  logic       armed;
  always_ff @(posedge clk) begin
    if (rst) up_ff <= 2'h0;
    else if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
  end
  assign armed = (up_ff == 2'h3);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  sequence s_std_write_empty;
    armed && !timing_mode_select_in && !empty_flag_n && !wr_en_n;
  endsequence
  sequence s_ft_write_empty;
    armed && timing_mode_select_in && output_ready_n && !wr_en_n;
  endsequence
  a_reset_flags:
    assert property (disable iff (1'b0) rst ##1 rst |-> !empty_flag_n && full_flag_n
      && !almost_empty_flag_n && half_full_flag_n && almost_full_flag_n)
    else $error("flags not at reset values");
  a_std_no_ready:
    assert property (armed && !timing_mode_select_in |-> output_ready_n && input_ready_n)
    else $error("ready flags active in standard mode");
  a_ft_no_empty:
    assert property (armed && timing_mode_select_in |-> empty_flag_n && full_flag_n)
    else $error("empty or full active in fall-through mode");
  a_empty_rise:
    assert property (s_std_write_empty |-> ##[1:3] empty_flag_n)
    else $error("empty flag did not rise after write");
  a_empty_fall:
    assert property (armed && !timing_mode_select_in && $fell(empty_flag_n)
      |-> !$past(rd_en_n, 2))
    else $error("empty flag fell without read two edges before");
  a_read_has_data:
    assert property (armed && !timing_mode_select_in && !rd_en_n |-> $past(empty_flag_n))
    else $error("read issued while empty");
  a_ft_first_word:
    assert property (s_ft_write_empty |-> ##[1:4] !output_ready_n)
    else $error("first word did not fall through");
  a_ft_ready_cause:
    assert property (armed && timing_mode_select_in && $fell(output_ready_n)
      |-> !$past(wr_en_n, 4))
    else $error("output ready not four edges after write");
  a_ft_fetch_valid:
    assert property (armed && timing_mode_select_in && !rd_en_n |-> !output_ready_n)
    else $error("fetch without valid word");
  a_ft_space_ready:
    assert property (armed && timing_mode_select_in && almost_full_flag_n |-> !input_ready_n)
    else $error("input ready high with space left");
  a_half_before_af:
    assert property (armed && !almost_full_flag_n |-> !half_full_flag_n)
    else $error("almost full without half full");
endmodule : dcff_link_asserts

// ---- bench/tb.sv ----
// testbench for fifo and controller joined by the link interface
// assumes default offsets and one clock of 50 MHz
`timescale 1ns/1ns
`include "dcff_defines.svh"
module tb
  import dcff_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst;
  logic       mode_sel;
  logic       wr_valid;
  dcff_word_t wr_data;
  logic       wr_ready;
  logic       rd_valid;
  dcff_word_t rd_data;
  logic       rd_ready;
  logic       first_word_fallthrough_mode_active;
  dcff_cnt_t  word_count;
  dcff_word_t wseq;
  dcff_word_t rseq;
  int         pushed;
  int         n_fail;
  int         tests_run;
  dcff_if link ();
  always #10 clk = ~clk;
  dcff_device dcff_device_i (.clk(clk), .rst(rst), .link(link.device),
    .first_word_fallthrough_mode_active(first_word_fallthrough_mode_active), .word_count(word_count));
  dcff_host dcff_host_i (.clk(clk), .rst(rst), .link(link.host), .mode_sel(mode_sel),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_ready(rd_ready));
  dcff_link_asserts dcff_link_asserts_i (.clk(clk), .rst(rst), .wr_en_n(link.wr_en_n),
    .rd_en_n(link.rd_en_n), .timing_mode_select_in(link.timing_mode_select_in),
    .empty_flag_n(link.empty_flag_n), .full_flag_n(link.full_flag_n),
    .output_ready_n(link.output_ready_n), .input_ready_n(link.input_ready_n),
    .almost_empty_flag_n(link.almost_empty_flag_n),
    .almost_full_flag_n(link.almost_full_flag_n), .half_full_flag_n(link.half_full_flag_n));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic final_report;
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic expire(string what);
    n_fail++;
    $display("BAD %s exp done got timeout", what);
    final_report();
  endtask : expire
  task automatic chk(string what, dcff_word_t exp, dcff_word_t got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic chkb(string what, logic exp, logic got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %b got %b", what, exp, got);
    end
  endtask : chkb
  task automatic push(int n);
    int g;
    for (int i = 0; i < n; i++) begin
      wr_valid <= 1'b1;
      wr_data  <= wseq;
      g = 0;
      do begin
        @(negedge clk);
        if (++g > 2000) expire("push");
      end while (wr_ready !== 1'b1);
      @(posedge clk);
      wseq++;
      pushed++;
    end
    wr_valid <= 1'b0;
    @(posedge clk);
  endtask : push
  task automatic settle(int lvl);
    int g = 0;
    @(negedge clk);
    while (word_count !== dcff_cnt_t'(lvl)) begin
      if (++g > 3000) expire("settle");
      @(negedge clk);
    end
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_reset(logic m);
    rst      <= 1'b1;
    mode_sel <= m;
    rd_ready <= 1'b0;
    pushed = 0;
    repeat (7) @(posedge clk);
    @(negedge clk);
    chkb("empty", 1'b0, link.empty_flag_n);
    chkb("full", 1'b1, link.full_flag_n);
    chk("count", '0, dcff_word_t'(word_count));
    @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chkb("mode", m, first_word_fallthrough_mode_active);
    chkb("input_ready", !m, link.input_ready_n);
    chkb("empty_idle", m, link.empty_flag_n);
    @(posedge clk);
    $display("reset mode %0d done", m);
  endtask : t_reset
  task automatic t_thresholds(logic m);
    int lv [4];
    int ft;
    ft = int'(m);
    lv = '{127 + ft, 128 + ft, 512 + ft, 513 + ft};
    foreach (lv[k]) begin
      push(lv[k] + 1 - pushed);
      settle(lv[k]);
      chkb("almost_empty", lv[k] >= `DCFF_DEF_EMPTY_OFS + 1 + ft,
        link.almost_empty_flag_n);
      chkb("half_full", lv[k] < `DCFF_HALF_CNT + 1 + ft, link.half_full_flag_n);
      chkb("almost_full", 1'b1, link.almost_full_flag_n);
      chkb("full", 1'b1, link.full_flag_n);
      @(posedge clk);
    end
    $display("thresholds mode %0d done", m);
  endtask : t_thresholds
  task automatic t_fill_drain(logic m);
    int   g = 0;
    logic ok;
    wr_valid <= 1'b1;
    wr_data  <= wseq;
    while (g < 100) begin
      @(negedge clk);
      ok = wr_ready;
      @(posedge clk);
      if (ok === 1'b1) begin
        wseq++;
        pushed++;
        wr_data <= wseq;
        g = 0;
      end else g++;
      if (pushed > 1100) expire("fill");
    end
    wr_valid <= 1'b0;
    @(negedge clk);
    chkb("stage_refuse", 1'b0, wr_ready);
    chkb("almost_full", 1'b0, link.almost_full_flag_n);
    chkb("input_ready", !m, link.input_ready_n);
    chkb("full", 1'b1, link.full_flag_n);
    @(posedge clk);
    rd_ready <= 1'b1;
    g = 0;
    while (rseq != wseq) begin
      @(negedge clk);
      if (rd_valid === 1'b1) begin
        chk("rd_data", rseq, rd_data);
        rseq++;
      end
      if (++g > 6000) expire("drain");
    end
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("count", '0, dcff_word_t'(word_count));
    chkb("empty", m, link.empty_flag_n);
    chkb("output_ready", 1'b1, link.output_ready_n);
    chkb("almost_empty", 1'b0, link.almost_empty_flag_n);
    chkb("half_full", 1'b1, link.half_full_flag_n);
    chkb("almost_full", 1'b1, link.almost_full_flag_n);
    @(posedge clk);
    $display("fill and drain mode %0d done", m);
  endtask : t_fill_drain
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    rst = 1'b1;
    mode_sel = 1'b0;
    wr_valid = 1'b0;
    wr_data = '0;
    rd_ready = 1'b0;
    wseq = '0;
    rseq = '0;
    n_fail = 0;
    tests_run = 0;
    @(posedge clk);
    for (int m = 0; m < 2; m++) begin
      t_reset(m[0]);
      t_thresholds(m[0]);
      t_fill_drain(m[0]);
    end
    final_report();
  end
endmodule : tb
